/* File: common/psm_params.svh */
// Constants for the power state manager: field positions, register map,
// per-state settings and reset values.
// Assumes inclusion from the design file and the bench by bare name.
`ifndef PSM_PARAMS_SVH
`define PSM_PARAMS_SVH

// Input port field positions
`define PSM_PERF_BIT      0
`define PSM_TEMP_MSB      3
`define PSM_TEMP_LSB      2
`define PSM_BATT_MSB      5
`define PSM_BATT_LSB      4
`define PSM_LOAD_MSB      7
`define PSM_LOAD_LSB      6

// Decode thresholds
`define PSM_BATT_LOW_MAX  2'h1
`define PSM_TEMP_HIGH_MIN 2'h2
`define PSM_LOAD_LOW_VAL  2'h0

// Packed setting {flag, v_mem, v_core2, v_core1, f_mem, f_core2, f_core1}
`define PSM_SET_NORMAL    16'h5692
`define PSM_SET_PERF      16'h7FFF
`define PSM_SET_LIGHT     16'hAA49
`define PSM_SET_HOT       16'hAADB
`define PSM_SET_BATT      16'h0000

// Output images that the settings above must produce
`define PSM_UIO_NORMAL    8'h56
`define PSM_UO_NORMAL     8'h49
`define PSM_UIO_HOT       8'hAB
`define PSM_UO_HOT        8'h6D
`define PSM_UIO_BATT      8'h00
`define PSM_UO_BATT       8'h00

// Register map, byte addresses
`define PSM_REG_CTRL      4'h0
`define PSM_REG_SWIN      4'h4
`define PSM_REG_STATUS    4'h8
`define PSM_REG_OUTS      4'hC

// Register fields and reset values
`define PSM_CTRL_SRC_BIT  0
`define PSM_CTRL_RST      1'h0
`define PSM_SWIN_RST      8'h00
`define PSM_OE_ALL        8'hFF

`endif

/* File: common/psm_pkg.sv */
// Types shared by the power state manager.
// Assumes psm_params.svh is reachable on the include path.
package psm_pkg;

  // Power states; default state comes first so reset code is obvious
  typedef enum logic [2:0]
  {
    PSM_DEFAULT,
    PSM_PERFORMANCE,
    PSM_LIGHT_LOAD,
    PSM_OVERHEAT,
    PSM_BATTERY_SAVING
  } psm_state_e;

  // One state's actuator settings
  typedef struct packed
  {
    logic       low_power_flag;
    logic [1:0] memory_voltage;
    logic [1:0] second_core_voltage;
    logic [1:0] first_core_voltage;
    logic [2:0] memory_frequency;
    logic [2:0] second_core_frequency;
    logic [2:0] first_core_frequency;
  } psm_setting_s;

endpackage : psm_pkg

/* File: verilog/psm_manager.sv */
// Power state manager: five-state machine driving voltage and frequency
// settings from an eight-bit input port, with an Avalon-MM register slave.
// Assumes all inputs synchronous to clk (25 MHz) and a synchronous reset.
//
// What this block does
// - Performance request is input bit 0, high means wanted.
// - Temperature level is input bits 3:2.
// - Battery charge level is input bits 5:4.
// - Workload is input bits 7:6, only two bits mapped.
// - State is re-evaluated and registered on every rising clock edge.
// - From default, performance request wins first and enters performance state.
// - From default without request, low battery enters battery-saving state.
// - Battery is low when its field is 00 or 01.
// - From default, otherwise high temperature enters overheat state.
// - Temperature is high when its field is 10 or 11.
// - From default, otherwise low workload enters light-load state.
// - Performance state drives maximum settings; request drop returns to default.
// - Light-load state drives reduced settings; returns when workload not low.
// - Overheat state drives moderate settings; returns when temperature not high.
// - Battery-saving state drives minimum settings; returns when battery not low.
// - Reset held low forces the default state.
// - Bidirectional bit 0 carries the low-power flag.
// - Bidirectional 2:1, 4:3, 6:5 carry voltages; bit 7 first core frequency bit 0.
// - Output bits 4:2 second core frequency, 7:5 memory frequency.
// - Default state outputs 01010110 and 010_010010.
// - Overheat state outputs 10101011 and 011_011011.
// - Battery-saving state drives all settings to zero.
`timescale 1ns/10ps
`default_nettype none
`include "psm_params.svh"

module psm_manager
#(
  parameter int IN_W   = 8,
  parameter int ADDR_W = 4
)
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [IN_W-1:0]     input_port,
  output logic      [7:0]          output_port,
  input  wire logic [7:0]          bidir_in,
  output logic      [7:0]          bidir_out,
  output logic      [7:0]          bidir_oe,
  input  wire logic [ADDR_W-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  output psm_pkg::psm_state_e      power_state
);
  import psm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Field decoders

  // Low battery: field 00 or 01
  function automatic logic batt_low(input logic [IN_W-1:0] v);
    batt_low = (v[`PSM_BATT_MSB:`PSM_BATT_LSB] <= `PSM_BATT_LOW_MAX);
  endfunction : batt_low

  // High temperature: field 10 or 11
  function automatic logic temp_high(input logic [IN_W-1:0] v);
    temp_high = (v[`PSM_TEMP_MSB:`PSM_TEMP_LSB] >= `PSM_TEMP_HIGH_MIN);
  endfunction : temp_high

  // Low workload: no threshold given, so only zero counts
  function automatic logic load_low(input logic [IN_W-1:0] v);
    load_low = (v[`PSM_LOAD_MSB:`PSM_LOAD_LSB] == `PSM_LOAD_LOW_VAL);
  endfunction : load_low

  // Settings table per state
  function automatic psm_setting_s state_setting(input psm_state_e s);
    case (s)
      PSM_DEFAULT:        state_setting = psm_setting_s'(`PSM_SET_NORMAL);
      PSM_PERFORMANCE:    state_setting = psm_setting_s'(`PSM_SET_PERF);
      PSM_LIGHT_LOAD:     state_setting = psm_setting_s'(`PSM_SET_LIGHT);
      PSM_OVERHEAT:       state_setting = psm_setting_s'(`PSM_SET_HOT);
      PSM_BATTERY_SAVING: state_setting = psm_setting_s'(`PSM_SET_BATT);
      default:            state_setting = psm_setting_s'(`PSM_SET_NORMAL);
    endcase
  endfunction : state_setting

  ////////////////////////////////////////////////////////////////////////////
  // Register slave

  logic        src_sw_q;      // 1: machine reads the software input byte
  logic [7:0]  sw_input_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  psm_state_e  state_q;
  psm_state_e  state_d;
  logic [7:0]  uo_q;
  logic [7:0]  uio_q;
  logic        bus_req;
  logic        wr_take;
  logic [IN_W-1:0] in_eff;
  psm_setting_s    set_d;

  // Every access waits one cycle so read data can come from a flop
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_q;
  assign wr_take         = avs_write & ack_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= bus_req & ~ack_q;
  end

  // Control and software input; only the low byte lane carries data
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      src_sw_q   <= `PSM_CTRL_RST;
      sw_input_q <= `PSM_SWIN_RST;
    end
    else if (wr_take && avs_byteenable[0])
    begin
      if (avs_address == `PSM_REG_CTRL)
        src_sw_q <= avs_writedata[`PSM_CTRL_SRC_BIT];
      if (avs_address == `PSM_REG_SWIN)
        sw_input_q <= avs_writedata[7:0];
    end
  end

  // Read data captured in the wait cycle; unmapped addresses read zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_q <= 32'h0000_0000;
    else if (avs_read && !ack_q)
    begin
      case (avs_address)
        `PSM_REG_CTRL:   rdata_q <= {31'h0000_0000, src_sw_q};
        `PSM_REG_SWIN:   rdata_q <= {24'h00_0000, sw_input_q};
        `PSM_REG_STATUS: rdata_q <= {29'h0000_0000, state_q};
        `PSM_REG_OUTS:   rdata_q <= {16'h0000, uio_q, uo_q};
        default:         rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // State machine

  // Pins drive the machine unless software has taken over for testing
  assign in_eff = src_sw_q ? IN_W'(sw_input_q) : input_port;

  // Next-state logic, default-state exits in priority order
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PSM_DEFAULT:
      begin
        if (in_eff[`PSM_PERF_BIT])
          state_d = PSM_PERFORMANCE;
        else if (batt_low(in_eff))
          state_d = PSM_BATTERY_SAVING;
        else if (temp_high(in_eff))
          state_d = PSM_OVERHEAT;
        else if (load_low(in_eff))
          state_d = PSM_LIGHT_LOAD;
      end
      PSM_PERFORMANCE:
        if (!in_eff[`PSM_PERF_BIT])
          state_d = PSM_DEFAULT;
      PSM_LIGHT_LOAD:
        if (!load_low(in_eff))
          state_d = PSM_DEFAULT;
      PSM_OVERHEAT:
        if (!temp_high(in_eff))
          state_d = PSM_DEFAULT;
      PSM_BATTERY_SAVING:
        if (!batt_low(in_eff))
          state_d = PSM_DEFAULT;
      default:
        state_d = PSM_DEFAULT;
    endcase
  end

  // State register, one decision per edge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_q <= PSM_DEFAULT;
    else
      state_q <= state_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pins

  // Settings of the next state; reset forces the default image
  assign set_d = state_setting(rst_n ? state_d : PSM_DEFAULT);

  // Decoded from next state so pins change on the same edge as the state
  always_ff @(posedge clk)
  begin
    uio_q <= {set_d.first_core_frequency[0], set_d.memory_voltage, set_d.second_core_voltage,
              set_d.first_core_voltage, set_d.low_power_flag};
    uo_q  <= {set_d.memory_frequency, set_d.second_core_frequency,
              set_d.first_core_frequency[2:1]};
  end

  assign output_port = uo_q;
  assign bidir_out   = uio_q;
  assign bidir_oe    = `PSM_OE_ALL;
  assign power_state = state_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence perf_seen;
    state_q == PSM_DEFAULT && in_eff[`PSM_PERF_BIT];
  endsequence

  sequence batt_seen;
    state_q == PSM_DEFAULT && !in_eff[`PSM_PERF_BIT] && in_eff[`PSM_BATT_MSB:`PSM_BATT_LSB] < 2'h2;
  endsequence

  perf_priority_a: assert property (@(posedge clk) disable iff (!rst_n)
    perf_seen |=> state_q == PSM_PERFORMANCE)
    else $error("performance request did not win from default");

  battery_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
    batt_seen |=> state_q == PSM_BATTERY_SAVING ##0 output_port == `PSM_UO_BATT)
    else $error("low battery did not enter battery saving");

  overheat_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == PSM_DEFAULT && !in_eff[0] && in_eff[5] && in_eff[3])
    |=> state_q == PSM_OVERHEAT)
    else $error("high temperature did not enter overheat");

  light_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == PSM_DEFAULT && !in_eff[0] && in_eff[5] && !in_eff[3] && in_eff[7:6] == 2'h0)
    |=> state_q == PSM_LIGHT_LOAD)
    else $error("low workload did not enter light load");

  perf_return_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == PSM_PERFORMANCE && !in_eff[0]) |=> state_q == PSM_DEFAULT)
    else $error("performance state did not return");

  light_return_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == PSM_LIGHT_LOAD && in_eff[7:6] != 2'h0) |=> state_q == PSM_DEFAULT)
    else $error("light load did not return");

  hot_return_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == PSM_OVERHEAT && !in_eff[3]) |=> state_q == PSM_DEFAULT)
    else $error("overheat did not return");

  batt_return_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == PSM_BATTERY_SAVING && in_eff[5]) |=> state_q == PSM_DEFAULT)
    else $error("battery saving did not return");

  reset_state_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> state_q == PSM_DEFAULT && bidir_out == `PSM_UIO_NORMAL)
    else $error("reset did not force default state");

  default_image_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == PSM_DEFAULT |-> bidir_out == `PSM_UIO_NORMAL && output_port == `PSM_UO_NORMAL)
    else $error("default outputs wrong");

  hot_image_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == PSM_OVERHEAT |-> bidir_out == `PSM_UIO_HOT && output_port == `PSM_UO_HOT)
    else $error("overheat outputs wrong");

  batt_image_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == PSM_BATTERY_SAVING |-> bidir_out == `PSM_UIO_BATT && output_port == `PSM_UO_BATT)
    else $error("battery saving outputs not zero");

  perf_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == PSM_PERFORMANCE |-> !bidir_out[0] && output_port == 8'hFF)
    else $error("performance outputs wrong");

  oe_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    bidir_oe == `PSM_OE_ALL)
    else $error("bidirectional enables not all high");

  // Pins and state are loaded together, so a held state means held pins
  outs_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
    $stable(state_q) |-> $stable(bidir_out) && $stable(output_port))
    else $error("outputs moved while state held");

  bus_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(avs_read) && !ack_q) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait cycle");

endmodule : psm_manager

`default_nettype wire

/* File: bench/psm_sensor_model.sv */
// Far-side model: sensor, battery and workload sources plus the unused pad inputs.
// Assumes the bench chooses each sample and changes it right after a rising edge.
`timescale 1ns/10ps
`default_nettype none

module psm_sensor_model
(
  input  wire logic       clk,
  input  wire logic [7:0] sense,
  output logic      [7:0] input_port,
  output logic      [7:0] bidir_in
);
  ////////////////////////////////////////////////////////////////////////////
  // Sensor byte passes straight through, one field set per bench sample
  assign input_port = sense;

  // Pad inputs toggle every cycle, so a design that wrongly listens shows it
  always @(posedge clk)
    bidir_in <= (bidir_in === 8'hA5) ? 8'h5A : 8'hA5;
endmodule : psm_sensor_model

`default_nettype wire

/* File: bench/dynamic_power_state_manager_bench.sv */
// Self-checking bench for the power state manager: registers, then link traffic.
// Assumes psm_params.svh on the include path and a 25 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "psm_params.svh"

module dynamic_power_state_manager_bench;
  import psm_pkg::*;

  logic        clk;
  logic        rst_n;
  logic [7:0]  sense;
  logic [7:0]  input_port;
  logic [7:0]  output_port;
  logic [7:0]  bidir_in;
  logic [7:0]  bidir_out;
  logic [7:0]  bidir_oe;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  psm_state_e  power_state;
  psm_state_e  exp_st;
  logic [7:0]  prev_v;
  logic [7:0]  v;
  logic [15:0] img;
  logic        rst_q;
  int          n_mismatch;
  int          n_tests;
  logic [7:0]  corner [18] = '{8'hF2, 8'h12, 8'hF2, 8'hF3, 8'hF2, 8'hEA, 8'hFA, 8'hFE, 8'h7A,
                               8'h01, 8'h00, 8'h11, 8'h38, 8'h30, 8'h70, 8'h31, 8'h30, 8'h20};

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 40 ns
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  psm_sensor_model u_model (.clk(clk), .sense(sense), .input_port(input_port), .bidir_in(bidir_in));

  psm_manager u_dut
  (
    .clk(clk), .rst_n(rst_n), .input_port(input_port), .output_port(output_port),
    .bidir_in(bidir_in), .bidir_out(bidir_out), .bidir_oe(bidir_oe),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .power_state(power_state)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reference machine, priority perf > battery low > hot > light load
  function automatic psm_state_e next_st(input psm_state_e s, input logic [7:0] i);
    case (s)
      PSM_DEFAULT:
        if (i[0]) return PSM_PERFORMANCE;
        else if (i[5:4] <= 2'h1) return PSM_BATTERY_SAVING;
        else if (i[3:2] >= 2'h2) return PSM_OVERHEAT;
        else if (i[7:6] == 2'h0) return PSM_LIGHT_LOAD;
        else return PSM_DEFAULT;
      PSM_PERFORMANCE: return i[0] ? s : PSM_DEFAULT;
      PSM_LIGHT_LOAD:  return (i[7:6] == 2'h0) ? s : PSM_DEFAULT;
      PSM_OVERHEAT:    return (i[3:2] >= 2'h2) ? s : PSM_DEFAULT;
      default:         return (i[5:4] <= 2'h1) ? s : PSM_DEFAULT;
    endcase
  endfunction : next_st

  // Pin image {bidir_out, output_port} for each state
  function automatic logic [15:0] image(input psm_state_e s);
    case (s)
      PSM_DEFAULT:     return {`PSM_UIO_NORMAL, `PSM_UO_NORMAL};
      PSM_PERFORMANCE: return 16'hFEFF;
      PSM_LIGHT_LOAD:  return 16'hAB24;
      PSM_OVERHEAT:    return {`PSM_UIO_HOT, `PSM_UO_HOT};
      default:         return {`PSM_UIO_BATT, `PSM_UO_BATT};
    endcase
  endfunction : image

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task automatic wrap_up();
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One Avalon-MM transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be,
                     output logic [31:0] rd);
    int k;
    @(posedge clk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    // Waitrequest and read data are both taken at the rising edge
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (k == 20)
    begin
      n_mismatch++;
      wrap_up();
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, 4'hF, d);
    check("readdata", d, exp);
  endtask : rdchk

  task automatic wr(input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] d;
    bus(1'b1, a, wd, be, d);
  endtask : wr

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    sense = 8'h60;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    n_mismatch = 0;
    n_tests = 0;
    void'($urandom(67));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    // Registers; 0x60 keeps the machine parked in the default state
    rdchk(`PSM_REG_CTRL, 32'h0);
    rdchk(`PSM_REG_STATUS, 32'h0);
    rdchk(`PSM_REG_OUTS, 32'h5649);
    wr(`PSM_REG_SWIN, 32'h01, 4'h1);
    rdchk(`PSM_REG_SWIN, 32'h01);
    wr(`PSM_REG_SWIN, 32'hFF, 4'h0);
    rdchk(`PSM_REG_SWIN, 32'h01);
    wr(4'h2, 32'hFF, 4'hF);
    rdchk(4'h2, 32'h0);
    wr(`PSM_REG_CTRL, 32'h1, 4'h1);
    rdchk(`PSM_REG_STATUS, 32'h1);
    rdchk(`PSM_REG_OUTS, 32'hFEFF);
    wr(`PSM_REG_STATUS, 32'h7, 4'hF);
    rdchk(`PSM_REG_STATUS, 32'h1);
    wr(`PSM_REG_CTRL, 32'h0, 4'h1);
    rdchk(`PSM_REG_STATUS, 32'h0);
    // Link traffic: corners first, then random bytes, with a reset mid-run
    exp_st = PSM_DEFAULT;
    prev_v = sense;
    rst_q = 1'b1;
    for (int i = 0; i < 400; i++)
    begin
      v = (i < 18) ? corner[i] : 8'($urandom());
      @(posedge clk);
      rst_n <= (i != 150);
      sense <= v;
      #1;
      exp_st = rst_q ? next_st(exp_st, prev_v) : PSM_DEFAULT;
      img = image(exp_st);
      check("power_state", {29'h0, power_state}, {29'h0, exp_st});
      check("bidir_out", {24'h0, bidir_out}, {24'h0, img[15:8]});
      check("output_port", {24'h0, output_port}, {24'h0, img[7:0]});
      check("bidir_oe", {24'h0, bidir_oe}, 32'hFF);
      rst_q = rst_n;
      prev_v = v;
    end
    wrap_up();
  end
endmodule : dynamic_power_state_manager_bench

`default_nettype wire
